// [fsc_defs.vh]
// constants for the fieldbus switch configuration decoder
`ifndef FSC_DEFS_VH
`define FSC_DEFS_VH
`define FSC_ADDR_REG 12'h000
`define FSC_CTRL_REG 12'h004
`define FSC_STAT_REG 12'h008
`define FSC_RAW_REG 12'h00c
`define FSC_BASE_LOW 8'h40
`define FSC_BASE_HIGH 8'h50
`define FSC_OPT_RATE 0
`define FSC_OPT_LEN 1
`define FSC_OPT_BASE 2
`define FSC_OPT_RSVD 3
`define FSC_LEN_SHORT 6'h11
`define FSC_LEN_LONG 6'h20
`define FSC_CTRL_RESET 1'b0
`define FSC_ST_VALID 0
`define FSC_ST_BAD 1
`define FSC_ST_NOADDR 2
`define FSC_ST_RATE 3
`define FSC_ST_LEN 4
`define FSC_ST_RSVD 5
`define FSC_WORD_ZERO 32'h00000000
`define FSC_ADDR_NONE 8'h00
`define FSC_DIGIT_NONE 4'h0
`define FSC_OPT_NONE 4'h0
`define FSC_LEN_NONE 6'h00
`define FSC_DIGIT_PAD 4'h0
`define FSC_AD_LSB 0
`define FSC_AD_EN 8
`define FSC_RAW_DIG_LSB 0
`define FSC_RAW_OPT_LSB 4
`define FSC_CTRL_HOLD 0
`endif

// [fsc_config_decode.v]
// switch capture and decode with apb status registers
//
// The APB register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
// How it works
// - option position 1 picks 4 or 10 mbps, position 2 picks a 17 or 32 byte payload.
// - rate 4 mbps with 32 byte payload is flagged invalid and the link stays unusable.
// - station address is the rotary digit plus base 40h, or 50h with position 3 on.
// - position 3 off with digit 0 marks the address disabled; position 3 on gives 50h.
// - default switches give address 41h, 10 mbps, 32 bytes with no fault raised.
// - switches are captured once after reset release and held until the next power-up.
module fsc_config_decode (
  input wire sys_clk,
  input wire rstn,
  input wire [3:0] address_rotary_digit,
  input wire [3:0] link_option_switch_bank,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg [7:0] station_address,
  output reg station_enabled,
  output reg rate_10m,
  output reg [5:0] payload_len,
  output reg config_valid,
  output reg config_bad
);
`include "fsc_defs.vh"

////////////////////////////////////////////////////////////////
// decode helpers

function [7:0] fsc_base_of;
  input base_on;
  begin
    if (base_on) begin
      fsc_base_of = `FSC_BASE_HIGH;
    end else begin
      fsc_base_of = `FSC_BASE_LOW;
    end
  end
endfunction

function fsc_noaddr;
  input [3:0] opt;
  input [3:0] digit;
  begin
    fsc_noaddr = ~opt[`FSC_OPT_BASE] & (digit == `FSC_DIGIT_NONE);
  end
endfunction

function fsc_bad;
  input [3:0] opt;
  begin
    fsc_bad = ~opt[`FSC_OPT_RATE] & opt[`FSC_OPT_LEN];
  end
endfunction

function [7:0] fsc_station;
  input [3:0] opt;
  input [3:0] digit;
  begin
    if (fsc_noaddr(opt, digit)) begin
      fsc_station = `FSC_ADDR_NONE;
    end else begin
      fsc_station = fsc_base_of(opt[`FSC_OPT_BASE]) + {`FSC_DIGIT_PAD, digit};
    end
  end
endfunction

function [5:0] fsc_len_of;
  input len_on;
  begin
    if (len_on) begin
      fsc_len_of = `FSC_LEN_LONG;
    end else begin
      fsc_len_of = `FSC_LEN_SHORT;
    end
  end
endfunction

function fsc_hit;
  input [11:0] addr;
  input [11:0] offset;
  begin
    fsc_hit = (addr == offset);
  end
endfunction

function [31:0] fsc_stat_word;
  input valid_bit;
  input bad_bit;
  input noaddr_bit;
  input rate_bit;
  input long_bit;
  input rsvd_bit;
  begin
    fsc_stat_word = `FSC_WORD_ZERO;
    fsc_stat_word[`FSC_ST_VALID] = valid_bit;
    fsc_stat_word[`FSC_ST_BAD] = bad_bit;
    fsc_stat_word[`FSC_ST_NOADDR] = noaddr_bit;
    fsc_stat_word[`FSC_ST_RATE] = rate_bit;
    fsc_stat_word[`FSC_ST_LEN] = long_bit;
    fsc_stat_word[`FSC_ST_RSVD] = rsvd_bit;
  end
endfunction

////////////////////////////////////////////////////////////////
// power-up capture

reg captured;
reg [3:0] held_digit;
reg [3:0] held_opt;
reg link_hold;
wire capture_now;
wire [7:0] next_station_address;
wire next_station_enabled;
wire next_rate_10m;
wire [5:0] next_payload_len;
wire next_bad;
wire next_noaddr;

assign capture_now = ~captured;
assign next_bad = fsc_bad(link_option_switch_bank);
assign next_noaddr = fsc_noaddr(link_option_switch_bank, address_rotary_digit);
assign next_station_address = fsc_station(link_option_switch_bank, address_rotary_digit);
assign next_station_enabled = ~next_noaddr & ~next_bad;
assign next_rate_10m = link_option_switch_bank[`FSC_OPT_RATE];
assign next_payload_len = fsc_len_of(link_option_switch_bank[`FSC_OPT_LEN]);

// one capture after reset release, then frozen until the next power-up
always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    captured <= 1'b0;
  end else if (capture_now) begin
    captured <= 1'b1;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    held_digit <= `FSC_DIGIT_NONE;
    held_opt <= `FSC_OPT_NONE;
  end else if (capture_now) begin
    held_digit <= address_rotary_digit;
    held_opt <= link_option_switch_bank;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    station_address <= `FSC_ADDR_NONE;
  end else if (capture_now) begin
    station_address <= next_station_address;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    station_enabled <= 1'b0;
  end else if (capture_now) begin
    station_enabled <= next_station_enabled;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    rate_10m <= 1'b0;
  end else if (capture_now) begin
    rate_10m <= next_rate_10m;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    payload_len <= `FSC_LEN_NONE;
  end else if (capture_now) begin
    payload_len <= next_payload_len;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    config_valid <= 1'b0;
  end else if (capture_now) begin
    config_valid <= ~next_bad;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    config_bad <= 1'b0;
  end else if (capture_now) begin
    config_bad <= next_bad;
  end
end

////////////////////////////////////////////////////////////////
// apb slave: answer in the access phase, no further wait states

wire setup_phase;
wire access_phase;
wire ctrl_write;
wire [31:0] addr_word;
wire [31:0] ctrl_word;
wire [31:0] stat_word;
wire [31:0] raw_word;
reg [31:0] next_prdata;
reg next_pslverr;

assign setup_phase = psel & ~penable;
assign access_phase = psel & penable & pready;
assign ctrl_write = access_phase & pwrite & fsc_hit(paddr, `FSC_CTRL_REG);

function [31:0] fsc_addr_word;
  input enabled_bit;
  input [7:0] addr;
  begin
    fsc_addr_word = `FSC_WORD_ZERO;
    fsc_addr_word[`FSC_AD_EN] = enabled_bit;
    fsc_addr_word[`FSC_AD_LSB +: 8] = addr;
  end
endfunction

function [31:0] fsc_raw_word;
  input [3:0] opt;
  input [3:0] digit;
  begin
    fsc_raw_word = `FSC_WORD_ZERO;
    fsc_raw_word[`FSC_RAW_DIG_LSB +: 4] = digit;
    fsc_raw_word[`FSC_RAW_OPT_LSB +: 4] = opt;
  end
endfunction

function [31:0] fsc_ctrl_word;
  input hold_bit;
  begin
    fsc_ctrl_word = `FSC_WORD_ZERO;
    fsc_ctrl_word[`FSC_CTRL_HOLD] = hold_bit;
  end
endfunction

assign addr_word = fsc_addr_word(station_enabled, station_address);
assign ctrl_word = fsc_ctrl_word(link_hold);
assign stat_word = fsc_stat_word(config_valid & ~link_hold, config_bad,
  ~station_enabled & ~config_bad, rate_10m, payload_len == `FSC_LEN_LONG,
  held_opt[`FSC_OPT_RSVD]);
assign raw_word = fsc_raw_word(held_opt, held_digit);

// read data and error formed in the setup phase, registered for the access phase
always @* begin
  next_prdata = `FSC_WORD_ZERO;
  next_pslverr = 1'b0;
  if (setup_phase) begin
    if (fsc_hit(paddr, `FSC_ADDR_REG)) begin
      next_prdata = addr_word;
    end else if (fsc_hit(paddr, `FSC_CTRL_REG)) begin
      next_prdata = ctrl_word;
    end else if (fsc_hit(paddr, `FSC_STAT_REG)) begin
      next_prdata = stat_word;
    end else if (fsc_hit(paddr, `FSC_RAW_REG)) begin
      next_prdata = raw_word;
    end else begin
      next_pslverr = 1'b1;
    end
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    pready <= 1'b0;
  end else begin
    pready <= setup_phase;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    pslverr <= 1'b0;
  end else begin
    pslverr <= next_pslverr;
  end
end

always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    prdata <= `FSC_WORD_ZERO;
  end else begin
    prdata <= next_prdata;
  end
end

// hold bit masks the valid flag software sees; captured settings stay untouched
always @(posedge sys_clk or negedge rstn) begin
  if (!rstn) begin
    link_hold <= `FSC_CTRL_RESET;
  end else if (ctrl_write) begin
    link_hold <= pwdata[`FSC_CTRL_HOLD];
  end
end
endmodule

// [fsc_inst.sv]
// switch panel model: rotary digit and option bank as the installer sets them
`timescale 1ns/100ps
module fsc_inst (
  input wire [3:0] digit_set,
  input wire [2:0] option_set,
  output wire [3:0] address_rotary_digit,
  output wire [3:0] link_option_switch_bank
);
  // reserved position always left off by the installer
  assign link_option_switch_bank = {1'b0, option_set};
  assign address_rotary_digit = digit_set;
endmodule

// [fsc_cfg_sva.sv]
// assertions on the decoded switch settings and the register bus answer
`timescale 1ns/100ps
module fsc_cfg_sva (
  input wire sys_clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire pready,
  input wire [7:0] station_address,
  input wire station_enabled,
  input wire rate_10m,
  input wire [5:0] payload_len,
  input wire config_valid,
  input wire config_bad
);
  addr_hold_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    rstn[*3] |-> $stable(station_address)) else $error("station address moved");
  len_legal_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> (payload_len == 6'h11) || (payload_len == 6'h20))
    else $error("payload length not 17 or 32");
  bad_combo_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    config_bad |-> !rate_10m && (payload_len == 6'h20) && !station_enabled && !config_valid)
    else $error("bad combination not handled");
  valid_flag_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) |-> (config_valid != config_bad)) else $error("valid and bad disagree");
  addr_window_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    station_enabled |-> ((station_address[7:4] == 4'h4) || (station_address[7:4] == 4'h5))
    && (station_address != 8'h40)) else $error("station address out of range");
  disabled_zero_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    $past(rstn) && !station_enabled && !config_bad |-> (station_address == 8'h00))
    else $error("disabled address not zero");
  ready_setup_a: assert property (@(posedge sys_clk) disable iff (!rstn)
    psel && !penable |=> pready) else $error("no ready after setup");
endmodule
bind fsc_config_decode fsc_cfg_sva chk (.sys_clk, .rstn, .psel, .penable, .pready,
  .station_address, .station_enabled, .rate_10m, .payload_len, .config_valid, .config_bad);

// [fieldbus_switch_config_decode_tb_top.sv]
// testbench: switch capture, decode and status registers
`timescale 1ns/100ps
`define CK(n, e, v) begin samples_checked++; if ((v) !== (e)) begin n_fail++; \
  $display("Error %s expected %h seen %h", n, e, v); end end
module fieldbus_switch_config_decode_tb_top;
  `include "fsc_defs.vh"
  reg sys_clk = 1'b0;
  reg rstn = 1'b0;
  reg psel = 1'b0;
  reg penable = 1'b0;
  reg pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h00000000;
  reg [3:0] digit_set = 4'h0;
  reg [2:0] option_set = 3'h0;
  reg [32:0] rd = 33'h000000000;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  wire [3:0] address_rotary_digit;
  wire [3:0] link_option_switch_bank;
  wire [31:0] prdata;
  wire pready;
  wire pslverr;
  wire [7:0] station_address;
  wire station_enabled;
  wire rate_10m;
  wire [5:0] payload_len;
  wire config_valid;
  wire config_bad;
  wire [17:0] cfg;
  assign cfg = {config_bad, config_valid, rate_10m, station_enabled, payload_len,
    station_address};
  fsc_inst who (
    .digit_set(digit_set),
    .option_set(option_set),
    .address_rotary_digit(address_rotary_digit),
    .link_option_switch_bank(link_option_switch_bank)
  );
  fsc_config_decode dut (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .address_rotary_digit(address_rotary_digit),
    .link_option_switch_bank(link_option_switch_bank),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .station_address(station_address),
    .station_enabled(station_enabled),
    .rate_10m(rate_10m),
    .payload_len(payload_len),
    .config_valid(config_valid),
    .config_bad(config_bad)
  );
  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 1000) begin
      n_fail++;
      report_and_stop;
    end
  end
  task report_and_stop;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) begin
        $display("TEST PASSED");
      end else begin
        $display("TEST FAILED");
      end
      $finish;
    end
  endtask
  // one transfer; the wait for pready is bounded only by the bench timeout
  task apb(input bit wr, input [11:0] a, input [31:0] d);
    begin
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = {pslverr, prdata};
      psel <= 1'b0;
      penable <= 1'b0;
      pwrite <= 1'b0;
    end
  endtask
  // power cycle with the given switches; settings stand one edge after release, the task returns three edges after
  task power_up(input [2:0] opt, input [3:0] dig);
    begin
      rstn <= 1'b0;
      option_set <= opt;
      digit_set <= dig;
      repeat (12) @(posedge sys_clk);
      rstn <= 1'b1;
      repeat (3) @(posedge sys_clk);
    end
  endtask
  task t_default;
    begin
      power_up(3'h3, 4'h1);
      `CK("default config", {1'b0, 1'b1, 1'b1, 1'b1, 6'h20, 8'h41}, cfg)
      apb(1'b0, `FSC_STAT_REG, 32'h00000000);
      `CK("default status", {1'b0, 32'h00000019}, rd)
    end
  endtask
  task t_bad_combo;
    begin
      power_up(3'h2, 4'h1);
      `CK("bad config", {1'b1, 1'b0, 1'b0, 1'b0, 6'h20, 8'h41}, cfg)
      apb(1'b0, `FSC_STAT_REG, 32'h00000000);
      `CK("bad status", {1'b0, 32'h00000012}, rd)
    end
  endtask
  task t_disabled;
    begin
      power_up(3'h0, 4'h0);
      `CK("legacy config", {1'b0, 1'b1, 1'b0, 1'b0, 6'h11, 8'h00}, cfg)
      apb(1'b0, `FSC_ADDR_REG, 32'h00000000);
      `CK("disabled address", {1'b0, 32'h00000000}, rd)
      apb(1'b0, `FSC_STAT_REG, 32'h00000000);
      `CK("disabled status", {1'b0, 32'h00000005}, rd)
    end
  endtask
  task t_base_high;
    begin
      power_up(3'h4, 4'h0);
      `CK("base high zero", {1'b0, 1'b1, 1'b0, 1'b1, 6'h11, 8'h50}, cfg)
      power_up(3'h5, 4'he);
      `CK("base high e", {1'b0, 1'b1, 1'b1, 1'b1, 6'h11, 8'h5e}, cfg)
    end
  endtask
  task t_hold;
    begin
      power_up(3'h7, 4'hf);
      `CK("long high f", {1'b0, 1'b1, 1'b1, 1'b1, 6'h20, 8'h5f}, cfg)
      option_set <= 3'h2;
      digit_set <= 4'h0;
      repeat (4) @(posedge sys_clk);
      `CK("held config", {1'b0, 1'b1, 1'b1, 1'b1, 6'h20, 8'h5f}, cfg)
      apb(1'b0, `FSC_ADDR_REG, 32'h00000000);
      `CK("held address", {1'b0, 32'h0000015f}, rd)
      apb(1'b0, `FSC_RAW_REG, 32'h00000000);
      `CK("held raw", {1'b0, 32'h0000007f}, rd)
      apb(1'b1, `FSC_CTRL_REG, 32'h00000001);
      apb(1'b0, `FSC_CTRL_REG, 32'h00000000);
      `CK("hold bit", {1'b0, 32'h00000001}, rd)
      apb(1'b0, `FSC_STAT_REG, 32'h00000000);
      `CK("held status", {1'b0, 32'h00000018}, rd)
      apb(1'b0, 12'h010, 32'h00000000);
      `CK("unmapped", {1'b1, 32'h00000000}, rd)
    end
  endtask
  initial begin
    t_default;
    t_bad_combo;
    t_disabled;
    t_base_high;
    t_hold;
    report_and_stop;
  end
endmodule
